// ### ldf_pkg.sv
/*
  Constants shared by the line delay buffer: memory shape, pointer limits,
  reset values and the size of the input staging FIFO.
  Assumes a SystemVerilog-2012 tool chain; holds definitions only.
*/
package ldf_pkg;

  // ---------------------------------------------------------------------
  // Line memory shape
  // ---------------------------------------------------------------------
  localparam int          LDF_DW        = 8;
  localparam int          LDF_DEPTH     = 5048;
  localparam int          LDF_AW        = 13;
  localparam logic [12:0] LDF_PTR_LAST  = 13'h13B7;
  localparam logic [12:0] LDF_PTR_ZERO  = 13'h0000;
  localparam logic [12:0] LDF_PTR_STEP  = 13'h0001;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0]  LDF_DATA_RST  = 8'h00;
  localparam logic        LDF_VALID_RST = 1'b0;

  // ---------------------------------------------------------------------
  // Input staging FIFO
  // ---------------------------------------------------------------------
  localparam int          LDF_FIFO_DEPTH = 16;

  // ---------------------------------------------------------------------
  // Pin synchroniser depth (flip-flops in series)
  // ---------------------------------------------------------------------
  localparam int          LDF_SYNC_STAGES = 2;

endpackage

// ### ldf_line_delay.sv
/*
  Line delay buffer: 5048 x 8 line memory with a write port on CLK_I fed
  through a 16-word staging FIFO, and a read port on its own clock
  RD_CLK_I. Each pointer has its own active-low enable and pointer reset.
  Assumes all enable and pointer-reset pins arrive asynchronously and are
  synchronised here; RD_CLK_I is unrelated in phase to CLK_I.
*/
`timescale 1ns/1ns

// -----------------------------------------------------------------------
// Two-stage synchroniser
// -----------------------------------------------------------------------
module ldf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;
  logic [W-1:0] held;

  always_ff @(posedge clk_i) begin
    meta <= d_i;
    held <= meta;
  end

  assign q_o = held;
endmodule

// -----------------------------------------------------------------------
// Staging FIFO with valid/ready on both sides
// -----------------------------------------------------------------------
module ldf_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);

  logic [W-1:0] store [0:D-1];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0]   cnt;
  logic [AW-1:0] next_wp;
  logic [AW-1:0] next_rp;
  logic [AW:0]   next_cnt;
  logic          push;
  logic          pop;

  assign in_ready_o  = (cnt != (AW+1)'(D));
  assign out_valid_o = (cnt != '0);
  assign out_data_o  = store[rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_wp  = wp;
    next_rp  = rp;
    next_cnt = cnt;
    if (push) begin
      next_wp = (wp == AW'(D - 1)) ? '0 : wp + AW'(1);
    end
    if (pop) begin
      next_rp = (rp == AW'(D - 1)) ? '0 : rp + AW'(1);
    end
    if (push && !pop) begin
      next_cnt = cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      next_cnt = cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      store[wp] <= in_data_i;
    end
  end

  AST_FIFO_FULL: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (cnt == (AW+1)'(D)) && !pop |=> (cnt == (AW+1)'(D)) && $stable(wp))
    else $error("FIFO accepted a word while full");
endmodule

// -----------------------------------------------------------------------
// Top: line memory with independent write and read pointers
// -----------------------------------------------------------------------
// Notes on behaviour
// - Write pointer reset seen on a write edge clears pointer, enable ignored.
// - Read pointer reset seen on a read edge clears pointer, enable ignored.
// - Enables low, resets once per line: each byte returns 5048 reads later.
// - Read enable inactive keeps read pointer still, giving an offset.
// - Delay n counts cycles between writing and reading the same cell.
// - Reading a line still being written yields undefined trailing bytes.
// - Either pointer reset works any time and returns its pointer to zero.
module ldf_line_delay
  import ldf_pkg::*;
(
  input  wire logic                      CLK_I,
  input  wire logic                      RSTN_I,
  input  wire logic                      RD_CLK_I,
  input  wire logic [ldf_pkg::LDF_DW-1:0] WR_DATA_I,
  input  wire logic                      WR_VALID_I,
  output logic                           WR_READY_O,
  input  wire logic                      WR_ENABLE_N_I,
  input  wire logic                      WR_POINTER_RESET_N_I,
  input  wire logic                      RD_ENABLE_N_I,
  input  wire logic                      RD_POINTER_RESET_N_I,
  output logic      [ldf_pkg::LDF_DW-1:0] RD_DATA_O,
  output logic                           RD_VALID_O
);
  import ldf_pkg::*;

  // ---------------------------------------------------------------------
  // Line memory
  // ---------------------------------------------------------------------
  logic [LDF_DW-1:0] line_mem [0:LDF_DEPTH-1];

  // ---------------------------------------------------------------------
  // Write side signals
  // ---------------------------------------------------------------------
  logic [1:0]        wr_pins;
  logic              wr_enable_n;
  logic              wr_pointer_reset_n;
  logic              stg_valid;
  logic              stg_ready;
  logic [LDF_DW-1:0] stg_data;
  logic              wr_fire;
  logic [LDF_AW-1:0] wr_ptr;
  logic [LDF_AW-1:0] next_wr_ptr;

  // ---------------------------------------------------------------------
  // Read side signals
  // ---------------------------------------------------------------------
  logic              rd_rstn;
  logic [1:0]        rd_pins;
  logic              rd_enable_n;
  logic              rd_pointer_reset_n;
  logic              rd_fire;
  logic [LDF_AW-1:0] rd_ptr;
  logic [LDF_AW-1:0] next_rd_ptr;
  logic [LDF_DW-1:0] rd_data;
  logic [LDF_DW-1:0] next_rd_data;
  logic              rd_valid;
  logic              next_rd_valid;

  // ---------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------
  ldf_sync #(.W(2)) u_wr_sync (
    .clk_i (CLK_I),
    .d_i   ({WR_ENABLE_N_I, WR_POINTER_RESET_N_I}),
    .q_o   (wr_pins)
  );

  ldf_sync #(.W(2)) u_rd_sync (
    .clk_i (RD_CLK_I),
    .d_i   ({RD_ENABLE_N_I, RD_POINTER_RESET_N_I}),
    .q_o   (rd_pins)
  );

  ldf_sync #(.W(1)) u_rd_rst_sync (
    .clk_i (RD_CLK_I),
    .d_i   (RSTN_I),
    .q_o   (rd_rstn)
  );

  assign wr_enable_n        = wr_pins[1];
  assign wr_pointer_reset_n = wr_pins[0];
  assign rd_enable_n        = rd_pins[1];
  assign rd_pointer_reset_n = rd_pins[0];

  // ---------------------------------------------------------------------
  // Staging FIFO in the write path
  // ---------------------------------------------------------------------
  ldf_fifo #(.W(LDF_DW), .D(LDF_FIFO_DEPTH)) u_stage (
    .clk_i       (CLK_I),
    .rstn_i      (RSTN_I),
    .in_valid_i  (WR_VALID_I),
    .in_ready_o  (WR_READY_O),
    .in_data_i   (WR_DATA_I),
    .out_valid_o (stg_valid),
    .out_ready_i (stg_ready),
    .out_data_o  (stg_data)
  );

  // Drain only while writing is enabled and the pointer is not held
  assign stg_ready = !wr_enable_n && wr_pointer_reset_n;
  assign wr_fire   = stg_valid && stg_ready;

  // ---------------------------------------------------------------------
  // Write pointer
  // ---------------------------------------------------------------------
  always_comb begin
    next_wr_ptr = wr_ptr;
    if (!wr_pointer_reset_n) begin
      next_wr_ptr = LDF_PTR_ZERO;
    end else if (wr_fire) begin
      if (wr_ptr == LDF_PTR_LAST) begin
        next_wr_ptr = LDF_PTR_ZERO;
      end else begin
        next_wr_ptr = wr_ptr + LDF_PTR_STEP;
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      wr_ptr <= LDF_PTR_ZERO;
    end else begin
      wr_ptr <= next_wr_ptr;
    end
  end

  // Store at the write pointer
  always_ff @(posedge CLK_I) begin
    if (wr_fire) begin
      line_mem[wr_ptr] <= stg_data;
    end
  end

  // ---------------------------------------------------------------------
  // Read pointer and output register
  // ---------------------------------------------------------------------
  assign rd_fire = !rd_enable_n && rd_pointer_reset_n;

  always_comb begin
    next_rd_ptr   = rd_ptr;
    next_rd_data  = rd_data;
    next_rd_valid = rd_fire;
    if (!rd_pointer_reset_n) begin
      next_rd_ptr = LDF_PTR_ZERO;
    end else if (rd_fire) begin
      // No guard against the writer: a cell not yet written reads stale
      next_rd_data = line_mem[rd_ptr];
      if (rd_ptr == LDF_PTR_LAST) begin
        next_rd_ptr = LDF_PTR_ZERO;
      end else begin
        next_rd_ptr = rd_ptr + LDF_PTR_STEP;
      end
    end
  end

  always_ff @(posedge RD_CLK_I) begin
    if (!rd_rstn) begin
      rd_ptr   <= LDF_PTR_ZERO;
      rd_data  <= LDF_DATA_RST;
      rd_valid <= LDF_VALID_RST;
    end else begin
      rd_ptr   <= next_rd_ptr;
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
    end
  end

  assign RD_DATA_O  = rd_data;
  assign RD_VALID_O = rd_valid;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  AST_WR_RESET: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    !wr_pointer_reset_n |=> (wr_ptr == LDF_PTR_ZERO))
    else $error("Write pointer not cleared by its reset");

  AST_WR_RESET_HELD: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (!wr_pointer_reset_n)[*3] |-> (wr_ptr == LDF_PTR_ZERO) && !wr_fire)
    else $error("Write pointer moved while reset held");

  AST_WR_ADVANCE: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    wr_fire && (wr_ptr != LDF_PTR_LAST)
      |=> (wr_ptr == $past(wr_ptr) + LDF_PTR_STEP))
    else $error("Write pointer did not advance by one");

  AST_WR_WRAP: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    wr_fire && (wr_ptr == LDF_PTR_LAST) |=> (wr_ptr == LDF_PTR_ZERO))
    else $error("Write pointer did not wrap after last cell");

  AST_RD_RESET: assert property (
    @(posedge RD_CLK_I) disable iff (!rd_rstn)
    !rd_pointer_reset_n |=> (rd_ptr == LDF_PTR_ZERO) && !rd_valid)
    else $error("Read pointer not cleared by its reset");

  AST_RD_HOLD: assert property (
    @(posedge RD_CLK_I) disable iff (!rd_rstn)
    rd_enable_n && rd_pointer_reset_n |=> $stable(rd_ptr) && !rd_valid)
    else $error("Read pointer moved while read disabled");

  AST_RD_ADVANCE: assert property (
    @(posedge RD_CLK_I) disable iff (!rd_rstn)
    rd_fire && (rd_ptr != LDF_PTR_LAST)
      |=> rd_valid && (rd_ptr == $past(rd_ptr) + LDF_PTR_STEP))
    else $error("Read pointer did not advance with valid data");

  AST_RD_WRAP: assert property (
    @(posedge RD_CLK_I) disable iff (!rd_rstn)
    rd_fire && (rd_ptr == LDF_PTR_LAST) |=> (rd_ptr == LDF_PTR_ZERO))
    else $error("Read pointer did not wrap after last cell");

endmodule

// ### ldf_reader.sv
/*
  Reader model at the read port: drives the read pins on RD_CLK_I and
  collects every byte that the buffer returns.
  Assumes the buffer synchronises both pins and marks reads with valid.
*/
`timescale 1ns/1ns

module ldf_reader (
  input  wire logic       rd_clk_i,
  input  wire logic       run_i,
  input  wire logic       slow_i,
  input  wire logic       clr_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            rd_enable_n_o,
  output logic            rd_pointer_reset_n_o
);
  logic [7:0] got [$];
  logic [4:0] lfsr = 5'h1F;

  // -------------------------------------------------------------------
  // Pin drive and capture
  // -------------------------------------------------------------------
  initial begin
    rd_enable_n_o        = 1'b1;
    rd_pointer_reset_n_o = 1'b0;
  end

  always @(posedge rd_clk_i) begin
    lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
    rd_pointer_reset_n_o <= !clr_i;
    rd_enable_n_o <= !(run_i && !(slow_i && lfsr[0]));
    if (rd_valid_i === 1'b1) begin
      got.push_back(rd_data_i);
    end
  end
endmodule

// ### test_line_delay_fifo.sv
/*
  Self-checking bench of the line delay buffer against a memory model.
  Assumes the reader model drives the read pins on a 6 ns clock.
*/
`timescale 1ns/1ns

module test_line_delay_fifo;
  import ldf_pkg::*;

  logic       CLK_I = 1'b0;
  logic       RSTN_I = 1'b0;
  logic       RD_CLK_I = 1'b0;
  logic [7:0] WR_DATA_I = 8'h00;
  logic       WR_VALID_I = 1'b0;
  logic       WR_READY_O;
  logic       WR_ENABLE_N_I = 1'b1;
  logic       WR_POINTER_RESET_N_I = 1'b0;
  logic       rd_enable_n;
  logic       rd_pointer_reset_n;
  logic [7:0] RD_DATA_O;
  logic       RD_VALID_O;
  logic       run = 1'b0;
  logic       slow = 1'b0;
  logic       clr = 1'b1;
  logic [7:0] mem [LDF_DEPTH];
  integer     wp = 0;
  integer     seed = 32'h5FB2;
  integer     n_errors = 0;
  integer     checks = 0;
  integer     cycles = 0;
  integer     cnt;
  bit         t;

  always #25 CLK_I = ~CLK_I;
  initial begin
    #1;
    forever #3 RD_CLK_I = ~RD_CLK_I;
  end

  ldf_line_delay dut_u (
    .CLK_I(CLK_I), .RSTN_I(RSTN_I), .RD_CLK_I(RD_CLK_I),
    .WR_DATA_I(WR_DATA_I), .WR_VALID_I(WR_VALID_I),
    .WR_READY_O(WR_READY_O), .WR_ENABLE_N_I(WR_ENABLE_N_I),
    .WR_POINTER_RESET_N_I(WR_POINTER_RESET_N_I),
    .RD_ENABLE_N_I(rd_enable_n),
    .RD_POINTER_RESET_N_I(rd_pointer_reset_n),
    .RD_DATA_O(RD_DATA_O), .RD_VALID_O(RD_VALID_O)
  );

  ldf_reader rdr_u (
    .rd_clk_i(RD_CLK_I), .run_i(run), .slow_i(slow), .clr_i(clr),
    .rd_data_i(RD_DATA_O), .rd_valid_i(RD_VALID_O),
    .rd_enable_n_o(rd_enable_n),
    .rd_pointer_reset_n_o(rd_pointer_reset_n)
  );

  // -------------------------------------------------------------------
  // Shared tasks
  // -------------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("checks=%0d mismatches=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Offer one byte; push keeps the same byte until it is taken
  task offer(input logic [7:0] d, output bit ok);
    WR_VALID_I <= 1'b1;
    WR_DATA_I  <= d;
    @(negedge CLK_I);
    ok = (WR_READY_O === 1'b1);
    @(posedge CLK_I);
    if (ok) begin
      mem[wp] = d;
      wp = (wp + 1) % LDF_DEPTH;
    end
  endtask

  task push(input integer n);
    logic [7:0] d;
    for (int k = 0; k < n; k++) begin
      d = 8'($random(seed));
      do offer(d, t); while (!t);
    end
    WR_VALID_I <= 1'b0;
    repeat (30) @(posedge CLK_I);
  endtask

  // Clear the read pointer, then read n bytes and compare
  task read_cmp(input integer n, input logic en);
    run <= en;
    clr <= 1'b1;
    repeat (4) @(posedge CLK_I);
    rdr_u.got.delete();
    run <= 1'b1;
    clr <= 1'b0;
    while (rdr_u.got.size() < n) @(posedge CLK_I);
    run <= 1'b0;
    for (int j = 0; j < n; j++) begin
      check(rdr_u.got[j], mem[j % LDF_DEPTH]);
    end
    repeat (4) @(posedge CLK_I);
  endtask

  always @(posedge CLK_I) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    repeat (16) @(posedge CLK_I);
    RSTN_I <= 1'b1;
    WR_ENABLE_N_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    check({7'h00, RD_VALID_O}, 8'h00);
    check(RD_DATA_O, 8'h00);
    WR_POINTER_RESET_N_I <= 1'b1;
    wp = 0;
    slow <= 1'b1;
    push(40);
    read_cmp(40, 1'b1);
    $display("short line with read stalls done");
    WR_ENABLE_N_I <= 1'b1;
    WR_POINTER_RESET_N_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    wp = 0;
    cnt = 0;
    do begin
      offer(8'($random(seed)), t);
      if (t) cnt++;
    end while (t);
    WR_VALID_I <= 1'b0;
    check(8'(cnt), 8'(LDF_FIFO_DEPTH));
    WR_POINTER_RESET_N_I <= 1'b1;
    WR_ENABLE_N_I <= 1'b0;
    repeat (4) @(posedge CLK_I);
    push(LDF_DEPTH + 24 - cnt);
    check({7'h00, WR_READY_O}, 8'h01);
    slow <= 1'b0;
    read_cmp(LDF_DEPTH + 24, 1'b0);
    $display("full line with pointer wrap done");
    wrap_up();
  end
endmodule
